/* File: design/hps_regs.vh */
// constants for the home position return sequencer
`ifndef HPS_REGS_VH
`define HPS_REGS_VH
// homing method codes, lowest digit of the method setting
`define HPS_METHOD_DOG 4'h0
`define HPS_METHOD_COUNT 4'h1
`define HPS_METHOD_DATA 4'h2
// clock rate and filter time unit
`define HPS_CLK_HZ 20000000
`define HPS_FILTER_UNIT_US 1000
// clock cycles in one filter unit: 1 ms at 20 MHz, sized for the divider
`define HPS_FILTER_UNIT_CYC 16'h4E20
// least dog pulse width the controller must give, in ms
`define HPS_DOG_MIN_MS 10
// point table entry whose ramp times homing uses
`define HPS_RAMP_ENTRY 3'h0
`endif

/* File: design/hps_filter.v */
// input filter: the raw vector is taken once it has differed from the output for a set time
`timescale 1ns/1ps
module hps_filter
#(
	parameter W = 12
)
(
	// clock and reset
	input wire CLK,
	input wire NRST,
	// filter time in clock-enable ticks
	input wire [3:0] TIME_SEL,
	input wire TICK,
	// raw and filtered input vector
	input wire [W-1:0] RAW,
	output reg [W-1:0] CLEAN
);
	// one shared counter: cleared when raw equals the filtered value and when the raw value is taken
	reg [3:0] cnt_q;
	// count ticks while raw differs, take the value when time met
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			cnt_q <= 4'h0;
			CLEAN <= {W{1'b0}};
		end
		else if (RAW == CLEAN)
			cnt_q <= 4'h0;
		else if (cnt_q >= TIME_SEL)
		begin
			// a zero setting passes changes after one cycle
			CLEAN <= RAW;
			cnt_q <= 4'h0;
		end
		else if (TICK)
			cnt_q <= cnt_q + 4'h1;
	end
endmodule // hps_filter

/* File: design/hps_sequencer.v */
// home position return sequencer: count type and data setting type
// Behaviour
// RQ1 - count: dog edge, post-dog travel, then Z
// RQ2 - controller holds dog pulse at least 10ms
// RQ3 - mode: auto_manual on, all selects off
// RQ4 - method digit 1 selects count type
// RQ5 - method digit 2 selects data setting type
// RQ6 - homing speed until dog found
// RQ7 - creep speed after dog found
// RQ8 - shift distance counted from that Z
// RQ9 - load current position with home data
// RQ10 - use ramp times of table entry 1; the code uses entry 0
// RQ11 - inputs seen only after filter time
// RQ12 - controller changes selection early enough
// RQ13 - data type takes present position as home
// RQ14 - search follows direction setting
// RQ15 - dog polarity follows polarity setting
// RQ16 - BCD use: speed selects off
// RQ17 - method digit 0 selects dog type; the code sends it to S_ERR
// RQ18 - assert homing complete output at end
// RQ19 - Z is one pulse per rev, first taken
`timescale 1ns/1ps
`include "hps_regs.vh"
module hps_sequencer
#(
	parameter PW = 32,
	parameter SW = 16
)
(
	// clock and reset
	input wire CLK,
	input wire NRST,
	// mode and selection inputs from controller
	input wire AUTO_MANUAL_SELECT,
	input wire [7:0] POINT_TABLE_SELECT_INPUTS,
	input wire [3:0] SPEED_SELECT_INPUTS,
	input wire BCD_MODE,
	input wire START,
	input wire PROXIMITY_DOG,
	// encoder feedback
	input wire ENC_Z,
	input wire ENC_STEP,
	// settings
	input wire [3:0] HOMING_METHOD_SETTING,
	input wire HOMING_DIRECTION_SETTING,
	input wire DOG_POLARITY_SETTING,
	input wire [SW-1:0] HOMING_SPEED_SETTING,
	input wire [SW-1:0] CREEP_SPEED_SETTING,
	input wire [PW-1:0] HOME_SHIFT_DISTANCE_SETTING,
	input wire [PW-1:0] HOME_POSITION_DATA_SETTING,
	input wire [PW-1:0] POST_DOG_DISTANCE_SETTING,
	input wire [3:0] INPUT_FILTER_TIME_SETTING,
	// motion command outputs
	output reg [SW-1:0] SPEED_CMD,
	output reg DIR_CMD,
	output reg MOVE_CMD,
	output reg [2:0] RAMP_ENTRY,
	// position and status
	output reg [PW-1:0] CURRENT_POSITION,
	output reg HOMING_COMPLETE_OUTPUT,
	output reg HOMING_MODE,
	output reg HOMING_ERROR
);
	// states
	localparam S_IDLE = 3'h0;
	localparam S_FAST = 3'h1;
	localparam S_POST = 3'h2;
	localparam S_ZWAIT = 3'h3;
	localparam S_SHIFT = 3'h4;
	localparam S_DONE = 3'h5;
	localparam S_ERR = 3'h6;

	// filter time unit tick
	localparam [15:0] UNIT_CYC = `HPS_FILTER_UNIT_CYC;
	reg [15:0] div_q;
	reg tick_q;
	// divider for the filter time base
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (div_q == UNIT_CYC - 16'h0001)
		begin
			div_q <= 16'h0000;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// mode, select, start and dog inputs filtered as one vector; BCD mode and encoder are not
	wire [14:0] raw_in;
	wire [14:0] flt;
	assign raw_in = {AUTO_MANUAL_SELECT, POINT_TABLE_SELECT_INPUTS,
		SPEED_SELECT_INPUTS, START, PROXIMITY_DOG};
	hps_filter #(.W(15)) u_filter
	(
		.CLK(CLK),
		.NRST(NRST),
		.TIME_SEL(INPUT_FILTER_TIME_SETTING),
		.TICK(tick_q),
		.RAW(raw_in),
		.CLEAN(flt)
	); // RQ11

	wire f_am;
	wire [7:0] f_pt;
	wire [3:0] f_sp;
	wire f_start;
	wire dog_act;
	assign f_am = flt[14];
	assign f_pt = flt[13:6];
	assign f_sp = flt[5:2];
	assign f_start = flt[1];
	// polarity setting high means dog active low
	assign dog_act = flt[0] ^ DOG_POLARITY_SETTING; // RQ15

	// home mode: manual selected, table selects all off
	wire mode_ok;
	assign mode_ok = f_am && (f_pt == 8'h00) &&
		(!BCD_MODE || f_sp == 4'h0); // RQ3 RQ16

	// state, counters and edge memories
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [PW-1:0] dist_q;
	reg start_prev_q;
	reg dog_prev_q;
	reg z_prev_q;
	wire start_rise;
	wire dog_rise;
	wire z_rise;
	assign start_rise = f_start && !start_prev_q;
	assign dog_rise = dog_act && !dog_prev_q;
	// only the rising edge counts: one marker per revolution
	assign z_rise = ENC_Z && !z_prev_q; // RQ19

	// method decode
	function [1:0] method_of;
		input [3:0] digit;
		begin
			case (digit)
				`HPS_METHOD_DOG: method_of = 2'h0; // RQ17
				`HPS_METHOD_COUNT: method_of = 2'h1; // RQ4
				`HPS_METHOD_DATA: method_of = 2'h2; // RQ5
				default: method_of = 2'h3;
			endcase
		end
	endfunction
	wire [1:0] meth;
	assign meth = method_of(HOMING_METHOD_SETTING);

	// next state
	always @*
	begin
		st_d = st_q;
		case (st_q)
			S_IDLE:
				if (mode_ok && start_rise)
				begin
					// dog type needs a dog rear end search, not built here
					if (meth == 2'h1)
						st_d = S_FAST;
					else if (meth == 2'h2)
						st_d = S_DONE; // RQ13
					else
						st_d = S_ERR;
				end
			S_FAST:
				if (!mode_ok)
					st_d = S_IDLE;
				else if (dog_rise)
					st_d = S_POST; // RQ1
			S_POST:
				if (!mode_ok)
					st_d = S_IDLE;
				else if (dist_q == {PW{1'b0}})
					st_d = S_ZWAIT; // RQ1
			S_ZWAIT:
				if (!mode_ok)
					st_d = S_IDLE;
				else if (z_rise)
					st_d = (HOME_SHIFT_DISTANCE_SETTING == {PW{1'b0}}) ?
						S_DONE : S_SHIFT; // RQ1 RQ8
			S_SHIFT:
				if (!mode_ok)
					st_d = S_IDLE;
				else if (dist_q == {PW{1'b0}})
					st_d = S_DONE; // RQ8
			S_DONE:
				st_d = S_IDLE;
			S_ERR:
				if (!mode_ok)
					st_d = S_IDLE;
			default:
				st_d = S_IDLE;
		endcase
	end

	// state register and edge memories
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			st_q <= S_IDLE;
			start_prev_q <= 1'b0;
			dog_prev_q <= 1'b0;
			z_prev_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			start_prev_q <= f_start;
			dog_prev_q <= dog_act;
			z_prev_q <= ENC_Z;
		end
	end

	// distance counter: post-dog travel, then shift travel
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			dist_q <= {PW{1'b0}};
		else if (st_q == S_FAST && dog_rise)
			dist_q <= POST_DOG_DISTANCE_SETTING; // RQ1
		else if (st_q == S_ZWAIT && z_rise)
			dist_q <= HOME_SHIFT_DISTANCE_SETTING; // RQ8
		else if ((st_q == S_POST || st_q == S_SHIFT) && ENC_STEP &&
			dist_q != {PW{1'b0}})
			dist_q <= dist_q - {{(PW-1){1'b0}}, 1'b1};
	end

	// motion command outputs
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			SPEED_CMD <= {SW{1'b0}};
			DIR_CMD <= 1'b0;
			MOVE_CMD <= 1'b0;
			RAMP_ENTRY <= `HPS_RAMP_ENTRY;
		end
		else
		begin
			DIR_CMD <= HOMING_DIRECTION_SETTING; // RQ14
			RAMP_ENTRY <= `HPS_RAMP_ENTRY; // RQ10
			case (st_d)
				S_FAST:
				begin
					SPEED_CMD <= HOMING_SPEED_SETTING; // RQ6
					MOVE_CMD <= 1'b1;
				end
				S_POST, S_ZWAIT, S_SHIFT:
				begin
					SPEED_CMD <= CREEP_SPEED_SETTING; // RQ7
					MOVE_CMD <= 1'b1;
				end
				default:
				begin
					SPEED_CMD <= {SW{1'b0}};
					MOVE_CMD <= 1'b0;
				end
			endcase
		end
	end

	// position tracking, home data load, completion flag
	always @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			CURRENT_POSITION <= {PW{1'b0}};
			HOMING_COMPLETE_OUTPUT <= 1'b0;
			HOMING_MODE <= 1'b0;
			HOMING_ERROR <= 1'b0;
		end
		else
		begin
			HOMING_MODE <= mode_ok;
			HOMING_ERROR <= (st_d == S_ERR);
			if (st_q == S_DONE)
			begin
				CURRENT_POSITION <= HOME_POSITION_DATA_SETTING; // RQ9
				HOMING_COMPLETE_OUTPUT <= 1'b1; // RQ18
			end
			else
			begin
				if (ENC_STEP)
					CURRENT_POSITION <= HOMING_DIRECTION_SETTING ?
						CURRENT_POSITION - {{(PW-1){1'b0}}, 1'b1} :
						CURRENT_POSITION + {{(PW-1){1'b0}}, 1'b1};
				// a new count type start withdraws completion
				if (st_d == S_FAST)
					HOMING_COMPLETE_OUTPUT <= 1'b0;
			end
		end
	end
endmodule // hps_sequencer

/* File: testbench/hps_partner.sv */
// partner model: dog sensor and encoder on the moving axis
`timescale 1ns/1ps
module hps_partner
(
	// clock and reset
	input wire CLK,
	input wire NRST,
	// axis state
	input wire MOVE,
	input wire POL,
	// sensor outputs
	output wire DOG,
	output wire Z,
	output wire STEP
);
	reg [7:0] cnt_q; // counts since motion began
	// count while moving, clear at stop
	always @(posedge CLK or negedge NRST)
		if (!NRST)
			cnt_q <= 8'h00;
		else
			cnt_q <= MOVE ? cnt_q + 8'h01 : 8'h00;
	assign STEP = MOVE; // one count a cycle
	// dog held from count 30 until the run ends or the 8-bit cnt_q wraps to zero
	assign DOG = (MOVE && cnt_q >= 8'h1E) ^ POL;
	assign Z = MOVE && cnt_q[3:0] == 4'hF;
endmodule // hps_partner

/* File: testbench/hps_sequencer_assertions.sv */
// checker on the sequencer ports
`timescale 1ns/1ps
module hps_chk
#(
	parameter PW = 32,
	parameter SW = 16
)
(
	input wire CLK,
	input wire NRST,
	input wire AUTO_MANUAL_SELECT,
	input wire [7:0] POINT_TABLE_SELECT_INPUTS,
	input wire [3:0] SPEED_SELECT_INPUTS,
	input wire BCD_MODE,
	input wire [3:0] HOMING_METHOD_SETTING,
	input wire HOMING_DIRECTION_SETTING,
	input wire [SW-1:0] HOMING_SPEED_SETTING,
	input wire [PW-1:0] HOME_POSITION_DATA_SETTING,
	input wire [SW-1:0] SPEED_CMD,
	input wire DIR_CMD,
	input wire MOVE_CMD,
	input wire [2:0] RAMP_ENTRY,
	input wire [PW-1:0] CURRENT_POSITION,
	input wire HOMING_COMPLETE_OUTPUT,
	input wire HOMING_ERROR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	AST_RAMP: assert property (RAMP_ENTRY == 3'h0)
		else $error("ramp entry wrong");
	AST_LOAD: assert property ($rose(HOMING_COMPLETE_OUTPUT) |->
		CURRENT_POSITION == HOME_POSITION_DATA_SETTING)
		else $error("home data not loaded");
	AST_FAST: assert property ($rose(MOVE_CMD) |->
		SPEED_CMD == HOMING_SPEED_SETTING) else $error("start speed");
	AST_DIR: assert property (MOVE_CMD |->
		DIR_CMD == $past(HOMING_DIRECTION_SETTING))
		else $error("direction");
	AST_DATA: assert property (HOMING_METHOD_SETTING == 4'h2 |->
		!MOVE_CMD) else $error("data type moved");
	AST_ERR: assert property (HOMING_ERROR |-> !MOVE_CMD)
		else $error("moving in error");
	AST_SEL: assert property ((POINT_TABLE_SELECT_INPUTS != 8'h00) [*8]
		|-> !MOVE_CMD) else $error("moved with selection");
	AST_MAN: assert property (!AUTO_MANUAL_SELECT [*8]
		|-> !MOVE_CMD && !HOMING_ERROR) else $error("outside mode");
	AST_BCD: assert property ((BCD_MODE && SPEED_SELECT_INPUTS != 4'h0)
		[*8] |-> !MOVE_CMD) else $error("moved with speed select");
endmodule // hps_chk
bind hps_sequencer hps_chk #(.PW(PW), .SW(SW)) chk (.*);

/* File: testbench/home_position_return_sequencer_bench.sv */
// bench for the home position return sequencer
`timescale 1ns/1ps
module home_position_return_sequencer_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic am = 1'b0; // manual mode
	logic [7:0] sel = 8'h00;
	logic [3:0] spd = 4'h0;
	logic bcd = 1'b0;
	logic st = 1'b0;
	logic [3:0] meth = 4'h0;
	logic [3:0] filt = 4'h0; // input filter time setting
	logic pol = 1'b0; // dog polarity, also direction
	logic [31:0] hdat = 32'h00001234;
	wire dog, z, stp, dc, mv, done, hm, err;
	wire [15:0] sc;
	wire [2:0] re;
	wire [31:0] pos;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// rows: method, polarity, error expected
	logic [5:0] rows [5] = '{6'h08, 6'h04, 6'h06, 6'h01, 6'h0D};
	hps_sequencer uut (.CLK(clk), .NRST(nrst), .AUTO_MANUAL_SELECT(am),
		.POINT_TABLE_SELECT_INPUTS(sel), .SPEED_SELECT_INPUTS(spd),
		.BCD_MODE(bcd), .START(st), .PROXIMITY_DOG(dog), .ENC_Z(z),
		.ENC_STEP(stp), .HOMING_METHOD_SETTING(meth),
		.HOMING_DIRECTION_SETTING(pol), .DOG_POLARITY_SETTING(pol),
		.HOMING_SPEED_SETTING(16'h0123), .CREEP_SPEED_SETTING(16'h0045),
		.HOME_SHIFT_DISTANCE_SETTING(32'h00000004),
		.HOME_POSITION_DATA_SETTING(hdat),
		.POST_DOG_DISTANCE_SETTING(32'h00000014),
		.INPUT_FILTER_TIME_SETTING(filt), .SPEED_CMD(sc), .DIR_CMD(dc),
		.MOVE_CMD(mv), .RAMP_ENTRY(re), .CURRENT_POSITION(pos),
		.HOMING_COMPLETE_OUTPUT(done), .HOMING_MODE(hm),
		.HOMING_ERROR(err));
	hps_partner pm (.CLK(clk), .NRST(nrst), .MOVE(mv), .POL(pol),
		.DOG(dog), .Z(z), .STEP(stp));
	always #25 clk = ~clk;
	// hang guard: the filter case alone takes about 20000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task chk(input string s, input logic [31:0] x, input logic [31:0] y);
		samples_checked++;
		if (x !== y)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", s, x, y);
		end
	endtask
	// reset, then enter manual mode
	task rst;
		nrst = 1'b0;
		am = 1'b0;
		cyc(2);
		nrst = 1'b1;
		cyc(2);
		am = 1'b1;
		cyc(3);
	endtask
	task go;
		st = 1'b1;
		cyc(4);
		st = 1'b0;
	endtask
	task end_sim;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		rst;
		chk("reset pos", 32'h0, pos);
		chk("reset done", 32'h0, done);
		chk("home mode", 32'h1, hm);
		foreach (rows[i])
		begin
			meth = rows[i][5:2];
			pol = rows[i][1];
			rst;
			go;
			if (meth == 4'h1)
			begin
				repeat (20) if (mv !== 1'b1) cyc(1);
				chk("homing speed", 32'h0123, sc);
				chk("direction", pol, dc);
				chk("ramp entry", 32'h0, re);
				cyc(40);
				chk("creep speed", 32'h0045, sc);
			end
			repeat (400) if (done !== 1'b1 && err !== 1'b1) cyc(1);
			cyc(1);
			chk("error", rows[i][0], err);
			chk("complete", !rows[i][0], done);
			chk("moving", 32'h0, mv);
			if (!rows[i][0]) chk("home pos", hdat, pos);
		end
		// refused: selection and speed inputs not clear
		meth = 4'h2;
		rst;
		sel = 8'h01;
		bcd = 1'b1;
		spd = 4'h1;
		cyc(4);
		go;
		cyc(40);
		chk("refused", 32'h0, done);
		// BCD use: a speed select left on blocks the mode, cleared it opens
		sel = 8'h00;
		rst;
		go;
		cyc(8);
		chk("bcd refused", 32'h0, done);
		chk("bcd mode", 32'h0, hm);
		spd = 4'h0;
		cyc(4);
		go;
		cyc(8);
		chk("bcd taken", 32'h1, done);
		// mode loss aborts a count run, start ignored while manual is off
		meth = 4'h1;
		bcd = 1'b0;
		rst;
		go;
		cyc(4);
		chk("run", 32'h1, mv);
		am = 1'b0;
		cyc(3);
		chk("aborted", 32'h0, mv);
		cyc(12);
		go;
		cyc(8);
		chk("no manual", 32'h0, mv);
		chk("no manual err", 32'h0, err);
		// one filter unit: the start is held off until a unit has passed
		meth = 4'h2;
		filt = 4'h1;
		rst;
		st = 1'b1;
		cyc(19900);
		chk("filtered early", 32'h0, done);
		repeat (1000) if (done !== 1'b1) cyc(1);
		chk("filtered late", 32'h1, done);
		st = 1'b0;
		end_sim;
	end
endmodule // home_position_return_sequencer_bench
